// ==== design/rct_defs.vh ====
/*
 constants of the reset-cause and time-out block: register indices, field positions,
 reset values, cause codes, oscillator modes and timing counts.
 assumes a 10 MHz pclk and an apb slave whose byte address is four times the index.
*/
`ifndef RCT_DEFS_VH
`define RCT_DEFS_VH

// ==========================================================================
// clock and timing
`define RCT_CLK_HZ 10000000
`define RCT_POWERUP_TIMER_TIME_MS 72
`define RCT_POWERUP_TIMER_CYCLES 20'd720000
`define RCT_OST_TOSC 1024
`define RCT_OST_CYCLES 20'd1024
`define RCT_WAKE_TIME_NS 6000
`define RCT_WAKE_CYCLES 20'd60

// ==========================================================================
// register indices (byte address = index * 4)
`define RCT_IDX_STATUS 10'h003
`define RCT_IDX_POWER_CONTROL_FLAGS 10'h08e
`define RCT_IDX_CFG 10'h090
`define RCT_IDX_CAUSE 10'h091
`define RCT_IDX_IRQ_STAT 10'h092
`define RCT_IDX_IRQ_MASK 10'h093

// ==========================================================================
// core status fields
`define RCT_ST_TIMEOUT 4
`define RCT_ST_POWERDOWN 3
`define RCT_STATUS_POR_VAL 8'h18

// power control fields
`define RCT_PC_OSC_SPEED_SELECT 3
`define RCT_PC_POR 1
`define RCT_PC_BOR 0

// config fields and reset value: [4] brown-out enable, [3] power-up delay disable, [2:0] osc mode
`define RCT_CFG_BROWNOUT_ENABLE_CFG 4
`define RCT_CFG_PWRTDIS 3
`define RCT_CFG_RST 5'h11

// ==========================================================================
// oscillator modes
`define RCT_OSC_LP 3'h0
`define RCT_OSC_XT 3'h1
`define RCT_OSC_HS 3'h2
`define RCT_OSC_EC 3'h3
`define RCT_OSC_RC 3'h4
`define RCT_OSC_INT 3'h5

// cause codes
`define RCT_C_NONE 3'h0
`define RCT_C_POR 3'h1
`define RCT_C_BOR 3'h2
`define RCT_C_MASTER_CLEAR_PIN 3'h3
`define RCT_C_MASTER_CLEAR_PIN_SLP 3'h4
`define RCT_C_WDT 3'h5
`define RCT_C_WDT_WAKE 3'h6
`define RCT_C_INT_WAKE 3'h7

// irq status bits
`define RCT_IRQ_W 6
`define RCT_IRQ_POR 0
`define RCT_IRQ_BOR 1
`define RCT_IRQ_MASTER_CLEAR_PIN 2
`define RCT_IRQ_WDT 3
`define RCT_IRQ_WAKE 4
`define RCT_IRQ_DONE 5

// program counter
`define RCT_PC_RESET 13'h0000
`define RCT_IRQ_VECTOR 13'h0004

`endif

// ==== design/rct_reset_cause.v ====
/*
 reset-cause recording and reset time-out sequencing with an apb register slave.
 assumes reset and wake events arrive as one-cycle pulses synchronous to pclk,
 and that the core honours core_hold and pc_load.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rct_defs.vh"

module rct_reset_cause #(
   parameter [19:0] POWERUP_TIMER_CYCLES = `RCT_POWERUP_TIMER_CYCLES
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire por_evt,
   input wire bor_evt,
   input wire master_clear_pin_evt,
   input wire wdt_evt,
   input wire int_wake_evt,
   input wire cpu_sleeping,
   input wire global_irq_enable,
   input wire [12:0] cur_pc,
   output reg core_hold,
   output reg pc_load,
   output reg [12:0] pc_load_value,
   output reg vector_jump,
   output reg irq
);

   // ======================================================================
   // state codes
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_POWERUP_TIMER = 3'h1;
   localparam [2:0] ST_OST = 3'h2;
   localparam [2:0] ST_WAKE = 3'h3;
   localparam [2:0] ST_DONE = 3'h4;
   localparam [2:0] ST_START = 3'h5;
   localparam [19:0] WAKE_CYC = `RCT_WAKE_CYCLES;
   localparam [7:0] STATUS_POR = `RCT_STATUS_POR_VAL;

   // ======================================================================
   // storage
   reg [2:0] status_hi_reg;
   reg timeout_n_reg;
   reg powerdown_n_reg;
   reg [2:0] status_lo_reg;
   reg osc_speed_reg;
   reg por_n_reg;
   reg bor_n_reg;
   reg [4:0] cfg_reg;
   reg [2:0] cause_reg;
   reg [2:0] state_reg;
   reg [19:0] cnt_reg;
   reg ost_pend_reg;
   reg [`RCT_IRQ_W-1:0] irq_stat_reg;
   reg [`RCT_IRQ_W-1:0] irq_mask_reg;

   // ======================================================================
   // helpers
   function [22:0] plan_phase;
      input use_powerup_timer;
      input use_ost;
      input use_wake;
      begin
         if (use_powerup_timer) begin
            plan_phase = {ST_POWERUP_TIMER, POWERUP_TIMER_CYCLES - 20'd1};
         end else if (use_ost) begin
            plan_phase = {ST_OST, `RCT_OST_CYCLES - 20'd1};
         end else if (use_wake) begin
            plan_phase = {ST_WAKE, WAKE_CYC - 20'd1};
         end else begin
            plan_phase = {ST_DONE, 20'd0};
         end
      end
   endfunction

   function hit;
      input [11:0] addr;
      input [9:0] idx;
      begin
         hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   // ======================================================================
   // event decode
   wire running = (state_reg == ST_RUN);
   wire crystal = (cfg_reg[2:0] == `RCT_OSC_LP) || (cfg_reg[2:0] == `RCT_OSC_XT) ||
                  (cfg_reg[2:0] == `RCT_OSC_HS);
   wire internal_osc_mode = (cfg_reg[2:0] == `RCT_OSC_INT);
   wire powerup_timer_on = ~cfg_reg[`RCT_CFG_PWRTDIS];
   wire e_bor = bor_evt & cfg_reg[`RCT_CFG_BROWNOUT_ENABLE_CFG];
   wire asleep = running & cpu_sleeping;
   wire e_wdt_wake = wdt_evt & asleep;
   wire e_int_wake = int_wake_evt & asleep;
   reg [2:0] evt_cause;
   always @* begin
      if (por_evt || state_reg == ST_START) begin
         evt_cause = `RCT_C_POR;
      end else if (e_bor) begin
         evt_cause = `RCT_C_BOR;
      end else if (master_clear_pin_evt && asleep) begin
         evt_cause = `RCT_C_MASTER_CLEAR_PIN_SLP;
      end else if (master_clear_pin_evt) begin
         evt_cause = `RCT_C_MASTER_CLEAR_PIN;
      end else if (e_wdt_wake) begin
         evt_cause = `RCT_C_WDT_WAKE;
      end else if (wdt_evt && running) begin
         evt_cause = `RCT_C_WDT;
      end else if (e_int_wake) begin
         evt_cause = `RCT_C_INT_WAKE;
      end else begin
         evt_cause = `RCT_C_NONE;
      end
   end

   wire is_pup = (evt_cause == `RCT_C_POR) || (evt_cause == `RCT_C_BOR);
   wire is_wake = (evt_cause == `RCT_C_WDT_WAKE) || (evt_cause == `RCT_C_INT_WAKE);
   wire e_any = (evt_cause != `RCT_C_NONE);
   wire [22:0] plan = plan_phase(is_pup & powerup_timer_on, crystal & (is_pup | is_wake),
                                 internal_osc_mode & is_wake);

   // ======================================================================
   // apb decode
   wire access = psel & penable;
   wire commit = access & pready;
   wire wr_lane = commit & pwrite & pstrb[0];
   wire mapped = hit(paddr, `RCT_IDX_STATUS) | hit(paddr, `RCT_IDX_POWER_CONTROL_FLAGS) |
                 hit(paddr, `RCT_IDX_CFG) | hit(paddr, `RCT_IDX_CAUSE) |
                 hit(paddr, `RCT_IDX_IRQ_STAT) | hit(paddr, `RCT_IDX_IRQ_MASK);
   wire [7:0] status_val = {status_hi_reg, timeout_n_reg, powerdown_n_reg, status_lo_reg};
   wire [7:0] power_control_flags_val = {4'h0, osc_speed_reg, 1'b0, por_n_reg, bor_n_reg};
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit(paddr, `RCT_IDX_STATUS)) begin
         rd_mux = {24'h00_0000, status_val};
      end else if (hit(paddr, `RCT_IDX_POWER_CONTROL_FLAGS)) begin
         rd_mux = {24'h00_0000, power_control_flags_val};
      end else if (hit(paddr, `RCT_IDX_CFG)) begin
         rd_mux = {27'h000_0000, cfg_reg};
      end else if (hit(paddr, `RCT_IDX_CAUSE)) begin
         rd_mux = {26'h000_0000, state_reg, cause_reg};
      end else if (hit(paddr, `RCT_IDX_IRQ_STAT)) begin
         rd_mux = {26'h000_0000, irq_stat_reg};
      end else if (hit(paddr, `RCT_IDX_IRQ_MASK)) begin
         rd_mux = {26'h000_0000, irq_mask_reg};
      end
   end

   // ======================================================================
   // register write strobes
   // a strobe fires only on the committing edge of a write
   wire wr_status = wr_lane & hit(paddr, `RCT_IDX_STATUS);
   wire wr_power_control_flags = wr_lane & hit(paddr, `RCT_IDX_POWER_CONTROL_FLAGS);
   wire wr_cfg = wr_lane & hit(paddr, `RCT_IDX_CFG);
   wire wr_istat = wr_lane & hit(paddr, `RCT_IDX_IRQ_STAT);
   wire wr_imask = wr_lane & hit(paddr, `RCT_IDX_IRQ_MASK);

   // ======================================================================
   // irq events
   reg [`RCT_IRQ_W-1:0] irq_set;
   always @* begin
      irq_set = {`RCT_IRQ_W{1'b0}};
      irq_set[`RCT_IRQ_POR] = (evt_cause == `RCT_C_POR);
      irq_set[`RCT_IRQ_BOR] = (evt_cause == `RCT_C_BOR);
      irq_set[`RCT_IRQ_MASTER_CLEAR_PIN] = (evt_cause == `RCT_C_MASTER_CLEAR_PIN) || (evt_cause == `RCT_C_MASTER_CLEAR_PIN_SLP);
      irq_set[`RCT_IRQ_WDT] = (evt_cause == `RCT_C_WDT);
      irq_set[`RCT_IRQ_WAKE] = is_wake;
      irq_set[`RCT_IRQ_DONE] = (state_reg == ST_DONE);
   end
   wire [`RCT_IRQ_W-1:0] irq_clr = wr_istat ?
                                   pwdata[`RCT_IRQ_W-1:0] : {`RCT_IRQ_W{1'b0}};
   wire [`RCT_IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

   // ======================================================================
   // apb slave, one wait cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         if (access && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ======================================================================
   // configuration and irq registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= `RCT_CFG_RST;
         irq_mask_reg <= {`RCT_IRQ_W{1'b0}};
         irq_stat_reg <= {`RCT_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else if (ce) begin
         if (wr_cfg) begin
            cfg_reg <= pwdata[4:0];
         end
         if (wr_imask) begin
            irq_mask_reg <= pwdata[`RCT_IRQ_W-1:0];
         end
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ======================================================================
   // flag registers: software write first, hardware event wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_hi_reg <= STATUS_POR[7:5];
         timeout_n_reg <= 1'b1;
         powerdown_n_reg <= 1'b1;
         status_lo_reg <= 3'h0;
         osc_speed_reg <= 1'b1;
         por_n_reg <= 1'b0;
         bor_n_reg <= 1'b0;
         cause_reg <= `RCT_C_POR;
      end else if (ce) begin
         if (wr_status) begin
            status_hi_reg <= pwdata[7:5];
            status_lo_reg <= pwdata[2:0];
         end
         if (wr_power_control_flags) begin
            osc_speed_reg <= pwdata[`RCT_PC_OSC_SPEED_SELECT];
            por_n_reg <= pwdata[`RCT_PC_POR];
            bor_n_reg <= pwdata[`RCT_PC_BOR];
         end
         if (e_any) begin
            cause_reg <= evt_cause;
         end
         case (evt_cause)
            `RCT_C_POR: begin
               status_hi_reg <= 3'h0;
               timeout_n_reg <= 1'b1;
               powerdown_n_reg <= 1'b1;
               status_lo_reg <= 3'h0;
               osc_speed_reg <= 1'b1;
               por_n_reg <= 1'b0;
            end
            `RCT_C_BOR: begin
               status_hi_reg <= 3'h0;
               timeout_n_reg <= 1'b1;
               powerdown_n_reg <= 1'b1;
               osc_speed_reg <= 1'b1;
               bor_n_reg <= 1'b0;
            end
            `RCT_C_MASTER_CLEAR_PIN: begin
               status_hi_reg <= 3'h0;
               osc_speed_reg <= 1'b1;
            end
            `RCT_C_MASTER_CLEAR_PIN_SLP: begin
               status_hi_reg <= 3'h0;
               timeout_n_reg <= 1'b1;
               powerdown_n_reg <= 1'b0;
               osc_speed_reg <= 1'b1;
            end
            `RCT_C_WDT: begin
               status_hi_reg <= 3'h0;
               timeout_n_reg <= 1'b0;
               osc_speed_reg <= 1'b1;
            end
            `RCT_C_WDT_WAKE: begin
               timeout_n_reg <= 1'b0;
               powerdown_n_reg <= 1'b0;
            end
            `RCT_C_INT_WAKE: begin
               timeout_n_reg <= 1'b1;
               powerdown_n_reg <= 1'b0;
            end
            default: begin
               cause_reg <= cause_reg;
            end
         endcase
      end
   end

   // ======================================================================
   // time-out sequencer and program counter load
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_START;
         cnt_reg <= 20'd0;
         ost_pend_reg <= 1'b0;
         core_hold <= 1'b1;
         pc_load <= 1'b0;
         pc_load_value <= `RCT_PC_RESET;
         vector_jump <= 1'b0;
      end else if (ce) begin
         pc_load <= 1'b0;
         if (e_any) begin
            state_reg <= plan[22:20];
            cnt_reg <= plan[19:0];
            ost_pend_reg <= crystal & (is_pup | is_wake) & (plan[22:20] == ST_POWERUP_TIMER);
            core_hold <= 1'b1;
            vector_jump <= 1'b0;
            if (is_wake) begin
               pc_load_value <= cur_pc + 13'h0001;
               vector_jump <= (evt_cause == `RCT_C_INT_WAKE) & global_irq_enable;
            end else begin
               pc_load_value <= `RCT_PC_RESET;
            end
         end else begin
            case (state_reg)
               ST_POWERUP_TIMER: begin
                  if (cnt_reg == 20'd0) begin
                     state_reg <= ost_pend_reg ? ST_OST : ST_DONE;
                     cnt_reg <= `RCT_OST_CYCLES - 20'd1;
                  end else begin
                     cnt_reg <= cnt_reg - 20'd1;
                  end
               end
               ST_OST, ST_WAKE: begin
                  if (cnt_reg == 20'd0) begin
                     state_reg <= ST_DONE;
                  end else begin
                     cnt_reg <= cnt_reg - 20'd1;
                  end
               end
               ST_DONE: begin
                  state_reg <= ST_RUN;
                  core_hold <= 1'b0;
                  pc_load <= 1'b1;
               end
               ST_RUN: begin
                  core_hold <= 1'b0;
               end
               default: begin
                  state_reg <= ST_DONE;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ==== tb/rct_reset_cause_chk.sv ====
/*
 concurrent checks on the ports of the reset-cause block.
 assumes one pclk domain, and that wake checks only see wakes in a mode with no wake delay.
*/
`timescale 1ns/10ps
`default_nettype none
module rct_reset_cause_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic por_evt,
   input wire logic master_clear_pin_evt,
   input wire logic wdt_evt,
   input wire logic int_wake_evt,
   input wire logic cpu_sleeping,
   input wire logic global_irq_enable,
   input wire logic [12:0] cur_pc,
   input wire logic core_hold,
   input wire logic pc_load,
   input wire logic [12:0] pc_load_value,
   input wire logic vector_jump
);
   // ==========================================================
   // sequences and properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_master_clear_pin_run;
      master_clear_pin_evt && ce && !core_hold && !por_evt;
   endsequence
   sequence s_release(logic [12:0] v);
      pc_load && !core_hold && pc_load_value == v;
   endsequence
   property p_master_clear_pin_pc;
      s_master_clear_pin_run |=> core_hold ##1 s_release(13'h0000);
   endproperty
   property p_wdt_wake;
      logic [12:0] v;
      (wdt_evt && ce && cpu_sleeping && !core_hold && !master_clear_pin_evt, v = cur_pc + 13'h1) |-> ##2 s_release(v);
   endproperty
   property p_int_vec;
      int_wake_evt && ce && cpu_sleeping && !core_hold && global_irq_enable && !wdt_evt && !master_clear_pin_evt
         |-> ##2 (pc_load && vector_jump);
   endproperty
   property p_hold_evt;
      (por_evt || master_clear_pin_evt) && ce |=> core_hold;
   endproperty
   property p_load_pulse;
      pc_load |=> !pc_load && !core_hold;
   endproperty
   property p_fell_load;
      $fell(core_hold) |-> pc_load;
   endproperty
   property p_apb_wait;
      psel && !penable && ce |=> !pready ##1 pready;
   endproperty
   property p_ready_one;
      pready |=> !pready;
   endproperty
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   // ==========================================================
   // assertions
   a_master_clear_pin_pc: assert property (p_master_clear_pin_pc) else $error("master_clear_pin release wrong");
   a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake pc wrong");
   a_int_vec: assert property (p_int_vec) else $error("int wake vector missing");
   a_hold_evt: assert property (p_hold_evt) else $error("core not held");
   a_load_pulse: assert property (p_load_pulse) else $error("pc load not a pulse");
   a_fell_load: assert property (p_fell_load) else $error("release without pc load");
   a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
   a_ready_one: assert property (p_ready_one) else $error("pready too long");
   a_err_zero: assert property (p_err_zero) else $error("error without ready or zero data");
endmodule
bind rct_reset_cause rct_reset_cause_chk rct_reset_cause_chk_inst (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .por_evt(por_evt), .master_clear_pin_evt(master_clear_pin_evt), .wdt_evt(wdt_evt),
   .int_wake_evt(int_wake_evt), .cpu_sleeping(cpu_sleeping), .global_irq_enable(global_irq_enable),
   .cur_pc(cur_pc), .core_hold(core_hold), .pc_load(pc_load), .pc_load_value(pc_load_value),
   .vector_jump(vector_jump));
`default_nettype wire

// ==== tb/rct_reset_cause_tb_top.sv ====
/*
 self-checking bench of the reset-cause block: apb tasks, event pulses, scenario tasks.
 assumes rct_defs.vh on the include path and a shortened power-up delay of 20 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rct_defs.vh"
module rct_reset_cause_tb_top;
   logic pclk, presetn, ce, psel, penable, pwrite, cpu_sleeping, global_irq_enable;
   logic pready, pslverr, core_hold, pc_load, vector_jump, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [12:0] cur_pc, pc_load_value;
   logic [4:0] evt;
   logic [7:0] rd;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   localparam logic [11:0] A_ST = {`RCT_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_PC = {`RCT_IDX_POWER_CONTROL_FLAGS, 2'b00};
   localparam logic [11:0] A_CF = {`RCT_IDX_CFG, 2'b00};
   localparam logic [11:0] A_CA = {`RCT_IDX_CAUSE, 2'b00};
   localparam logic [11:0] A_IS = {`RCT_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_IM = {`RCT_IDX_IRQ_MASK, 2'b00};
   // ==========================================================
   // design and clock
   rct_reset_cause #(.POWERUP_TIMER_CYCLES(20'd20)) rct_reset_cause_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .por_evt(evt[0]), .bor_evt(evt[1]), .master_clear_pin_evt(evt[2]), .wdt_evt(evt[3]), .int_wake_evt(evt[4]),
      .cpu_sleeping(cpu_sleeping), .global_irq_enable(global_irq_enable), .cur_pc(cur_pc),
      .core_hold(core_hold), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .vector_jump(vector_jump), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk({err, rd}, {1'b0, exp});
   endtask
   task automatic pulse(input int i);
      @(posedge pclk);
      evt <= 5'h1 << i;
      @(posedge pclk);
      evt <= 5'h0;
   endtask
   task automatic release_wait(input logic [12:0] pc);
      n = 0;
      while (pc_load !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) begin
         error_cnt++;
         $display("Error %0t: no core release", $time);
      end
      chk(pc_load_value, pc);
   endtask
   task automatic ev(input int i, input logic [12:0] pc, input logic [7:0] st, input logic [7:0] pcn,
                     input logic [2:0] cs);
      pulse(i);
      release_wait(pc);
      rdc(A_ST, st);
      rdc(A_PC, pcn);
      apb(1'b0, A_CA, 8'h00);
      chk(rd[2:0], cs);
   endtask
   task automatic wait_chk_irq(input logic exp);
      repeat (2) @(posedge pclk);
      chk(irq, exp);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_por;
      release_wait(13'h0000);
      chk(n >= 1044 && n <= 1050, 1);
      rdc(A_ST, 8'h18);
      rdc(A_PC, 8'h08);
      rdc(A_IS, 8'h21);
   endtask
   task automatic t_regs;
      apb(1'b1, A_PC, 8'hff);
      rdc(A_PC, 8'h0b);
      apb(1'b1, A_ST, 8'h00);
      rdc(A_ST, 8'h18);
      apb(1'b1, A_ST, 8'he7);
      rdc(A_ST, 8'hff);
      apb(1'b0, 12'h100, 8'h00);
      chk({err, rd}, {1'b1, 8'h00});
   endtask
   task automatic t_run;
      ev(2, 13'h0000, 8'h1f, 8'h0b, 3'h3);
      chk(n, 2);
      ev(3, 13'h0000, 8'h0f, 8'h0b, 3'h5);
   endtask
   task automatic t_sleep;
      apb(1'b1, A_CF, 8'h13);
      rdc(A_CF, 8'h13);
      cpu_sleeping <= 1'b1;
      cur_pc <= 13'h0abc;
      ev(2, 13'h0000, 8'h17, 8'h0b, 3'h4);
      ev(3, 13'h0abd, 8'h07, 8'h0b, 3'h6);
      ev(4, 13'h0abd, 8'h17, 8'h0b, 3'h7);
      chk(vector_jump, 1'b0);
      apb(1'b1, A_CF, 8'h15);
      ev(4, 13'h0abd, 8'h17, 8'h0b, 3'h7);
      chk(n > 60 && n < 64, 1);
      apb(1'b1, A_CF, 8'h13);
      global_irq_enable <= 1'b1;
      cur_pc <= 13'h1fff;
      ev(4, 13'h0000, 8'h17, 8'h0b, 3'h7);
      chk(vector_jump, 1'b1);
      cpu_sleeping <= 1'b0;
      global_irq_enable <= 1'b0;
   endtask
   task automatic t_bor;
      ev(1, 13'h0000, 8'h1f, 8'h0a, 3'h2);
      chk(n > 20 && n < 26, 1);
      apb(1'b1, A_PC, 8'h0b);
      apb(1'b1, A_CF, 8'h1b);
      ev(1, 13'h0000, 8'h1f, 8'h0a, 3'h2);
      chk(n, 2);
      apb(1'b1, A_PC, 8'h0b);
      apb(1'b1, A_CF, 8'h03);
      pulse(1);
      repeat (3) @(posedge pclk);
      chk(core_hold, 1'b0);
      rdc(A_PC, 8'h0b);
   endtask
   task automatic t_irq;
      apb(1'b1, A_IM, 8'h3f);
      wait_chk_irq(1'b1);
      apb(1'b1, A_IS, 8'h3f);
      rdc(A_IS, 8'h00);
      wait_chk_irq(1'b0);
      apb(1'b1, A_IM, 8'h04);
      pulse(3);
      release_wait(13'h0000);
      wait_chk_irq(1'b0);
      pulse(2);
      release_wait(13'h0000);
      wait_chk_irq(1'b1);
      rdc(A_IS, 8'h2c);
      apb(1'b1, A_IS, 8'h04);
      wait_chk_irq(1'b0);
   endtask
   task automatic t_ce;
      ce <= 1'b0;
      pulse(2);
      repeat (2) @(posedge pclk);
      chk(core_hold, 1'b0);
      chk(irq, 1'b0);
      ce <= 1'b1;
      rdc(A_CA, 8'h03);
      rdc(A_IS, 8'h28);
   endtask
   // ==========================================================
   // run control
   task automatic summarize;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      evt = 5'h00;
      cpu_sleeping = 1'b0;
      global_irq_enable = 1'b0;
      cur_pc = 13'h0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_por();
      t_regs();
      t_run();
      t_sleep();
      t_bor();
      t_irq();
      t_ce();
      summarize();
   end
endmodule
`default_nettype wire
